/* tb/serial_frame_port_with_io_pins_bench.sv */
// Self-checking bench for both ends of the serial frame port
module serial_frame_port_with_io_pins_bench
    import sfp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        i_clk_sys = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        h_start   = 1'b0;   // Host frame request
    sfp_word_t   h_tx      = '0;
    sfp_word_t   d_tx      = '0;
    logic        cfg_we    = 1'b0;
    logic [15:0] cfg_modes = '0;
    logic        cfg_busy  = 1'b0;
    logic        adc_busy  = 1'b0;
    logic [7:0]  gp_out    = '0;
    logic [7:0]  pin_in    = '0;
    logic        h_busy, h_rv, d_rv, b_rv, d_fa;
    sfp_word_t   h_rx, d_rx, b_rx;
    logic [7:0]  gp_in, adc_r, dac_r, p_out, p_oe_n;
    sfp_word_t   q_dev[$], q_host[$], q_b[$];   // Expected words, oldest first
    int          err_total    = 0;
    int          total_checks = 0;
    logic [31:0] rnd          = 32'he0ee;

    sfp_link_if link_a ();   // Host end against device end
    sfp_link_if link_b ();   // Bench-driven link, breaks host habits

    always #50 i_clk_sys = ~i_clk_sys;

    ////////////////////////////////////////////////////////////////////////
    sfp_host sfp_host_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .io_link(link_a.host),
        .i_start(h_start), .i_tx_word(h_tx), .o_busy(h_busy), .o_rx_word(h_rx),
        .o_rx_valid(h_rv));
    sfp_dev sfp_dev_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .io_link(link_a.dev),
        .i_tx_word(d_tx), .o_rx_word(d_rx), .o_rx_valid(d_rv), .o_frame_active(d_fa),
        .i_cfg_we(cfg_we), .i_cfg_modes(cfg_modes), .i_cfg_busy_en(cfg_busy),
        .i_adc_busy(adc_busy), .i_gpio_out(gp_out), .o_gpio_in(gp_in), .o_adc_route(adc_r),
        .o_dac_route(dac_r), .i_pin_in(pin_in), .o_pin_out(p_out), .o_pin_oe_n(p_oe_n));
    sfp_dev sfp_dev_b_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .io_link(link_b.dev),
        .i_tx_word(d_tx), .o_rx_word(b_rx), .o_rx_valid(b_rv), .o_frame_active(),
        .i_cfg_we(cfg_we), .i_cfg_modes(cfg_modes), .i_cfg_busy_en(cfg_busy),
        .i_adc_busy(adc_busy), .i_gpio_out(gp_out), .o_gpio_in(), .o_adc_route(),
        .o_dac_route(), .i_pin_in(pin_in), .o_pin_out(), .o_pin_oe_n());
    sfp_link_checker sfp_link_checker_inst (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
        .sclk(link_a.sclk), .cs_n(link_a.cs_n), .serial_data_in(link_a.serial_data_in), .serial_data_out(link_a.serial_data_out),
        .sdo_oe_n(link_a.sdo_oe_n), .sdo_line(link_a.sdo_line));

    ////////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge, never on it
    task automatic tick(input int n = 1);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    // Single comparison point
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Thirty-two shifts per call, so successive values are not neighbours
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        repeat (32) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
        return x;
    endfunction

    // Empty queue yields unknown, so a stray result always mismatches
    function automatic sfp_word_t pop(ref sfp_word_t q[$]);
        return (q.size() != 0) ? q.pop_front() : 'x;
    endfunction

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Expected pin roles from a mode word; pin 7 follows busy when enabled
    task automatic pin_check(input logic [15:0] m, input logic be);
        logic [7:0] e_adc, e_dac, e_in, dm, mk;
        for (int g = 0; g < 8; g++)
        begin
            e_adc[g] = m[2*g+:2] == SFP_MODE_ADC;
            e_dac[g] = m[2*g+:2] == SFP_MODE_DAC;
            e_in[g]  = (m[2*g+:2] == SFP_MODE_DIN) & pin_in[g];
            dm[g]    = m[2*g+:2] == SFP_MODE_DOUT;
        end
        mk    = be ? 8'h7f : 8'hff;
        dm[7] = dm[7] | be;
        check(16'(p_oe_n), {8'h00, ~dm});
        check(16'(p_out), 16'((be ? {adc_busy, gp_out[6:0]} : gp_out) & dm));
        check({adc_r, dac_r}, {e_adc & mk, e_dac & mk});
        check(16'(gp_in), 16'(e_in & mk));
    endtask

    // Bench-made frame at 800 ns; sel low clocks with frame select high
    task automatic b_frame(input sfp_word_t w, input int falls, input logic sel);
        link_b.cs_n = !sel;
        tick(4);
        for (int k = 0; k < falls; k++)
        begin
            link_b.serial_data_in  = w[15 - (k % 16)];
            tick(4);
            link_b.sclk = 1'b0;
            tick(4);
            link_b.sclk = 1'b1;
        end
        tick(4);
        link_b.cs_n = 1'b1;
        link_b.serial_data_in  = ~link_b.serial_data_in;   // Released line shows no stale bit
        tick(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Result watcher: oldest expectation against each valid pulse
    always
    begin
        @(posedge i_clk_sys);
        #2;
        if (d_rv === 1'b1) check(d_rx, pop(q_dev));
        if (d_rv === 1'b1) check(16'(d_fa), 16'h0001);
        if (h_rv === 1'b1) check(h_rx, pop(q_host));
        if (b_rv === 1'b1) check(b_rx, pop(q_b));
    end

    // Watchdog, several times the expected run
    initial
    begin
        #500000;
        err_total++;
        give_verdict();
    end

    // Main sequence
    initial
    begin
        link_b.sclk = 1'b1;
        link_b.cs_n = 1'b1;
        link_b.serial_data_in  = 1'b0;
        tick(6);
        i_arst_n = 1'b1;
        tick(4);
        // Back-to-back host frames with fresh pin roles each time
        for (int i = 0; i < 4; i++)
        begin
            rnd       = lfsr(rnd);
            h_tx      = rnd[15:0];
            d_tx      = rnd[31:16];
            rnd       = lfsr(rnd);
            cfg_modes = (i == 0) ? 16'he4e4 : rnd[15:0];
            gp_out    = rnd[23:16];
            pin_in    = rnd[31:24];
            cfg_busy  = i[0];
            adc_busy  = rnd[3];
            cfg_we    = 1'b1;
            tick();
            cfg_we    = 1'b0;
            tick(4);
            pin_check(cfg_modes, cfg_busy);
            q_dev.push_back(h_tx);
            q_host.push_back(d_tx);
            h_start = 1'b1;
            tick();
            h_start = 1'b0;
            check(16'(h_busy), 16'h0001);
            for (int n = 0; n < 400 && h_busy !== 1'b0; n++)
                tick();
        end
        // Deselected clocking, short frame, then overlong frame
        rnd = lfsr(rnd);
        b_frame(rnd[15:0], 6, 1'b0);
        b_frame(rnd[31:16], 5, 1'b1);
        q_b.push_back(rnd[15:0]);
        b_frame(rnd[15:0], 17, 1'b1);
        check(16'(q_dev.size() + q_host.size() + q_b.size()), 16'h0000);
        // Reset in mid-run acts without a clock edge
        i_arst_n = 1'b0;
        #5;
        check(16'(p_oe_n), 16'h00ff);
        check({adc_r, dac_r}, 16'h0000);
        check(16'(link_a.sdo_oe_n), 16'h0001);
        tick(2);
        i_arst_n = 1'b1;
        tick(4);
        pin_check(16'haaaa, 1'b0);
        give_verdict();
    end
endmodule // serial_frame_port_with_io_pins_bench

/* tb/sfp_link_checker.sv */
// Concurrent checks on the serial link joining the host and device ends
module sfp_link_checker (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic sdo_oe_n,
    input wire logic sdo_line
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    ////////////////////////////////////////////////////////////////////////
    // Helper: falls of the serial clock inside the open frame
    logic       sclk_q;   // Last sampled serial clock
    logic [4:0] falls_q;  // Falls seen since frame select fell
    logic [4:0] falls_d;

    // Cleared while deselected, so a frame cannot inherit counts
    assign falls_d = cs_n ? 5'h00 : falls_q + 5'(sclk_q & ~sclk);

    // Short register; reset matches the idle link
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sclk_q  <= 1'b1;
            falls_q <= 5'h00;
        end
        else
        begin
            sclk_q  <= sclk;
            falls_q <= falls_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link relations
    property p_idle;
        cs_n |-> sclk;
    endproperty
    a_idle: assert property (p_idle)
        else $error("serial clock low while deselected");
    property p_half;
        $changed(sclk) |=> $stable(sclk) [*3];
    endproperty
    a_half: assert property (p_half)
        else $error("serial clock half period too short");
    property p_lead;
        $fell(cs_n) |-> sclk [*4];
    endproperty
    a_lead: assert property (p_lead)
        else $error("first fall too soon after select");
    property p_gap;
        $rose(cs_n) |-> cs_n [*3];
    endproperty
    a_gap: assert property (p_gap)
        else $error("deselect time too short");
    property p_len;
        $rose(cs_n) |-> falls_q == 5'h10;
    endproperty
    a_len: assert property (p_len)
        else $error("frame did not carry sixteen falls");
    property p_msb;
        $fell(cs_n) |-> ##[1:6] !sdo_oe_n;
    endproperty
    a_msb: assert property (p_msb)
        else $error("data out not driven after select");
    property p_release;
        cs_n [*5] |-> sdo_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("data out driven while deselected");
    property p_sdo_hold;
        !cs_n && $fell(sclk) |=> $stable(serial_data_out) [*3];
    endproperty
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("data out moved in low half");
    property p_sdi_hold;
        !cs_n && !sclk |-> $stable(serial_data_in);
    endproperty
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("data in moved in low half");
endmodule // sfp_link_checker

/* verilog/sfp_dev.sv */
// Device end: serial frame port and eight multi-function pins
`include "sfp_regs.svh"

module sfp_dev
    import sfp_pkg::*;
#(
    parameter int FRAME_BITS = `SFP_FRAME_BITS,
    parameter int PINS       = `SFP_PIN_COUNT
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_arst_n,
    sfp_link_if.dev                    io_link,
    input  wire logic [FRAME_BITS-1:0] i_tx_word,
    output logic      [FRAME_BITS-1:0] o_rx_word,
    output logic                       o_rx_valid,
    output logic                       o_frame_active,
    input  wire logic                  i_cfg_we,
    input  wire logic [2*PINS-1:0]     i_cfg_modes,
    input  wire logic                  i_cfg_busy_en,
    input  wire logic                  i_adc_busy,
    input  wire logic [PINS-1:0]       i_gpio_out,
    output logic      [PINS-1:0]       o_gpio_in,
    output logic      [PINS-1:0]       o_adc_route,
    output logic      [PINS-1:0]       o_dac_route,
    input  wire logic [PINS-1:0]       i_pin_in,
    output logic      [PINS-1:0]       o_pin_out,
    output logic      [PINS-1:0]       o_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Link synchronisers

    logic [2:0] link_s1_q;      // First stage: sclk, cs_n, sdi
    logic [2:0] link_s2_q;      // Second stage, first logic-visible copy
    logic [2:0] link_s3_q;      // Previous value for edge detection

    // All three link lines pass the same depth so data stays aligned to clock
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            link_s1_q <= 3'h3;
            link_s2_q <= 3'h3;
            link_s3_q <= 3'h3;
        end
        else
        begin
            link_s1_q <= {io_link.serial_data_in, io_link.cs_n, io_link.sclk};
            link_s2_q <= link_s1_q;
            link_s3_q <= link_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge decode

    wire logic sclk_now   = link_s2_q[0];   // Synchronised serial clock
    wire logic sclk_prev  = link_s3_q[0];   // One cycle older
    wire logic cs_n_now   = link_s2_q[1];   // Synchronised frame select
    wire logic cs_n_prev  = link_s3_q[1];   // One cycle older
    wire logic sdi_now    = link_s2_q[2];   // Data aligned with sclk_now

    wire logic sclk_fall  = sclk_prev & ~sclk_now;
    wire logic sclk_rise  = ~sclk_prev & sclk_now;
    wire logic frame_open = cs_n_prev & ~cs_n_now;
    wire logic in_frame   = ~cs_n_now & ~cs_n_prev;

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path

    logic [FRAME_BITS-1:0] rx_shift_q;     // Input shift register
    logic [`SFP_CNT_W-1:0] rx_cnt_q;       // Falling edges taken this frame
    logic                  armed_q;        // A falling edge awaits its rise
    logic [FRAME_BITS-1:0] tx_shift_q;     // Outgoing word, MSB on the pin

    localparam logic [`SFP_CNT_W-1:0] LAST_CNT = `SFP_CNT_W'(FRAME_BITS);

    // Only falling edges inside an open frame count; extra ones are dropped
    wire logic take_bit  = in_frame & sclk_fall & (rx_cnt_q != LAST_CNT);
    wire logic word_done = take_bit & (rx_cnt_q == LAST_CNT - `SFP_CNT_W'(1));
    // Rising edge advances output only once a falling edge has been seen
    wire logic shift_out = in_frame & sclk_rise & armed_q;

    // Shift and count; only the count restarts when a frame opens
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rx_shift_q <= '0;
            rx_cnt_q   <= '0;
        end
        else if (frame_open)
        begin
            rx_cnt_q <= '0;
        end
        else if (take_bit)
        begin
            rx_shift_q <= {rx_shift_q[FRAME_BITS-2:0], sdi_now};
            rx_cnt_q   <= rx_cnt_q + `SFP_CNT_W'(1);
        end
    end

    // Completed word, presented with a one-cycle strobe
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rx_word  <= '0;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= word_done;
            if (word_done)
            begin
                o_rx_word <= {rx_shift_q[FRAME_BITS-2:0], sdi_now};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path

    // Arm on a fall, disarm on the rise that consumes it; idle level is free
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            armed_q <= 1'b0;
        end
        else if (frame_open || !in_frame)
        begin
            armed_q <= 1'b0;
        end
        else if (sclk_fall)
        begin
            armed_q <= 1'b1;
        end
        else if (sclk_rise)
        begin
            armed_q <= 1'b0;
        end
    end

    // Load at frame open so the MSB stands before the first edge
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_shift_q <= '0;
        end
        else if (frame_open)
        begin
            tx_shift_q <= i_tx_word;
        end
        else if (shift_out)
        begin
            tx_shift_q <= {tx_shift_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // Output driven only while a frame is open, so other slaves may share it
    logic sdo_oe_n_q;   // Registered enable, low while driving

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sdo_oe_n_q <= 1'b1;
        end
        else
        begin
            sdo_oe_n_q <= cs_n_now;
        end
    end

    assign io_link.serial_data_out      = tx_shift_q[FRAME_BITS-1];
    assign io_link.sdo_oe_n = sdo_oe_n_q;
    assign o_frame_active   = ~sdo_oe_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin configuration

    logic busy_en_q;    // Top pin shows conversion busy

    // Reset forces defaults regardless of link clock activity
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            busy_en_q <= `SFP_BUSY_EN_RST;
        end
        else if (i_cfg_we)
        begin
            busy_en_q <= i_cfg_busy_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-pin logic

    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            sfp_pin_mode_e mode_q;   // Role of this pin
            logic          in_s1_q;  // Pin input, first stage
            logic          in_s2_q;  // Pin input, second stage
            logic          busy_pin; // Busy overrides this pin

            // Each pin keeps its own mode; a write updates all at once
            always_ff @(posedge i_clk_sys or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    mode_q <= sfp_pin_mode_e'(`SFP_PIN_MODE_RST);
                end
                else if (i_cfg_we)
                begin
                    mode_q <= sfp_pin_mode_e'(i_cfg_modes[2*g +: 2]);
                end
            end

            // Top pin only; busy wins over the chosen role
            assign busy_pin = (g == `SFP_TOP_PIN) && busy_en_q;

            // Pin level from outside, two stages before use
            always_ff @(posedge i_clk_sys or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    in_s1_q <= 1'b0;
                    in_s2_q <= 1'b0;
                end
                else
                begin
                    in_s1_q <= i_pin_in[g];
                    in_s2_q <= in_s1_q;
                end
            end

            // Registered pin outputs and routing flags
            always_ff @(posedge i_clk_sys or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    o_pin_out[g]   <= 1'b0;
                    o_pin_oe_n[g]  <= 1'b1;
                    o_gpio_in[g]   <= 1'b0;
                    o_adc_route[g] <= 1'b0;
                    o_dac_route[g] <= 1'b0;
                end
                else if (busy_pin)
                begin
                    o_pin_out[g]   <= i_adc_busy;
                    o_pin_oe_n[g]  <= 1'b0;
                    o_gpio_in[g]   <= 1'b0;
                    o_adc_route[g] <= 1'b0;
                    o_dac_route[g] <= 1'b0;
                end
                else
                begin
                    // Digital driver only in output mode; converters use analog path
                    o_pin_out[g]   <= (mode_q == SFP_MODE_DOUT) & i_gpio_out[g];
                    o_pin_oe_n[g]  <= (mode_q != SFP_MODE_DOUT);
                    o_gpio_in[g]   <= (mode_q == SFP_MODE_DIN) & in_s2_q;
                    o_adc_route[g] <= (mode_q == SFP_MODE_ADC);
                    o_dac_route[g] <= (mode_q == SFP_MODE_DAC);
                end
            end
        end
    endgenerate

endmodule // sfp_dev

/* verilog/sfp_host.sv */
// Host end: serial clock divider and sixteen-bit frame sequencer
`include "sfp_regs.svh"

module sfp_host
    import sfp_pkg::*;
#(
    parameter int FRAME_BITS = `SFP_FRAME_BITS,
    parameter int HALF_CYC   = `SFP_SCLK_HALF_DEF
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_arst_n,
    sfp_link_if.host                   io_link,
    input  wire logic                  i_start,
    input  wire logic [FRAME_BITS-1:0] i_tx_word,
    output logic                       o_busy,
    output logic      [FRAME_BITS-1:0] o_rx_word,
    output logic                       o_rx_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // Timing

    // Never faster than the read limit, since any frame may read back
    localparam int HALF = (HALF_CYC > `SFP_SCLK_HALF_MIN_CYC) ?
                          HALF_CYC : `SFP_SCLK_HALF_MIN_CYC;
    localparam int HW   = $clog2(HALF + 1);

    sfp_host_state_e       state_q;     // Sequencer state
    logic [HW-1:0]         tick_q;      // Cycles left in this half period
    logic [`SFP_CNT_W-1:0] bit_q;       // Bits clocked this frame
    logic [FRAME_BITS-1:0] tx_q;        // Outgoing shift, MSB on the line
    logic [FRAME_BITS-1:0] rx_q;        // Incoming shift
    logic                  sdo_s1_q;    // Data in, first stage
    logic                  sdo_s2_q;    // Data in, second stage

    localparam logic [HW-1:0]         HALF_LD  = HW'(HALF - 1);
    localparam logic [`SFP_CNT_W-1:0] LAST_BIT = `SFP_CNT_W'(FRAME_BITS - 1);

    wire logic half_end = (tick_q == '0);
    wire logic last_bit = (bit_q == LAST_BIT);

    ////////////////////////////////////////////////////////////////////////////////
    // Data-in synchroniser

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sdo_s1_q <= 1'b1;
            sdo_s2_q <= 1'b1;
        end
        else
        begin
            sdo_s1_q <= io_link.sdo_line;
            sdo_s2_q <= sdo_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Half-period counter

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tick_q <= '0;
        end
        else if (state_q == SFP_H_IDLE || half_end)
        begin
            tick_q <= HALF_LD;
        end
        else
        begin
            tick_q <= tick_q - HW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame sequencer

    // Clock idles high; each bit is a low half then a high half
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q    <= SFP_H_IDLE;
            bit_q      <= '0;
            tx_q       <= '0;
            rx_q       <= '0;
            o_rx_word  <= '0;
            o_rx_valid <= 1'b0;
        end
        else
        begin
            o_rx_valid <= 1'b0;
            unique case (state_q)
                SFP_H_IDLE:
                begin
                    if (i_start)
                    begin
                        tx_q    <= i_tx_word;
                        bit_q   <= '0;
                        state_q <= SFP_H_LEAD;
                    end
                end
                SFP_H_LEAD:
                begin
                    if (half_end)
                    begin
                        state_q <= SFP_H_LOW;
                    end
                end
                SFP_H_LOW:
                begin
                    if (half_end)
                    begin
                        // Data moves on the rise, clear of the sampling fall
                        tx_q    <= {tx_q[FRAME_BITS-2:0], 1'b0};
                        state_q <= SFP_H_HIGH;
                    end
                end
                SFP_H_HIGH:
                begin
                    // Sample just before the device moves to the next bit
                    if (half_end)
                    begin
                        rx_q <= {rx_q[FRAME_BITS-2:0], sdo_s2_q};
                        if (last_bit)
                        begin
                            o_rx_word  <= {rx_q[FRAME_BITS-2:0], sdo_s2_q};
                            o_rx_valid <= 1'b1;
                            state_q    <= SFP_H_TAIL;
                        end
                        else
                        begin
                            bit_q   <= bit_q + `SFP_CNT_W'(1);
                            state_q <= SFP_H_LOW;
                        end
                    end
                end
                SFP_H_TAIL:
                begin
                    if (half_end)
                    begin
                        state_q <= SFP_H_GAP;
                    end
                end
                SFP_H_GAP:
                begin
                    // Frame select high time before another frame
                    if (half_end)
                    begin
                        state_q <= SFP_H_IDLE;
                    end
                end
                default:
                begin
                    state_q <= SFP_H_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link drive

    // Exactly sixteen falling edges fall inside each frame
    assign io_link.cs_n = (state_q == SFP_H_IDLE) || (state_q == SFP_H_GAP);
    assign io_link.sclk = (state_q != SFP_H_LOW);
    assign io_link.serial_data_in  = tx_q[FRAME_BITS-1];
    assign o_busy       = (state_q != SFP_H_IDLE);

endmodule // sfp_host

/* verilog/sfp_link_if.sv */
// Serial link between the host end and the device end
interface sfp_link_if;

    logic sclk;       // Serial clock, made by the host
    logic cs_n;       // Frame select, active low
    logic serial_data_in;        // Serial data toward the device
    logic serial_data_out;        // Serial data from the device
    logic sdo_oe_n;   // Device drives serial data out while low
    logic sdo_line;   // Resolved line level, pulled high when undriven

    // Undriven output reads as the pull-up level
    assign sdo_line = sdo_oe_n ? 1'b1 : serial_data_out;

    modport host (
        output sclk,
        output cs_n,
        output serial_data_in,
        input  sdo_line
    );

    modport dev (
        input  sclk,
        input  cs_n,
        input  serial_data_in,
        output serial_data_out,
        output sdo_oe_n
    );

endinterface

/* verilog/sfp_pkg.sv */
// Types shared by both ends of the serial frame port
package sfp_pkg;

    // Role of one multi-function pin
    typedef enum logic [1:0] {
        SFP_MODE_DAC  = 2'h0,   // Converter output, digital driver off
        SFP_MODE_ADC  = 2'h1,   // Converter input, digital driver off
        SFP_MODE_DIN  = 2'h2,   // Digital input
        SFP_MODE_DOUT = 2'h3    // Digital output
    } sfp_pin_mode_e;

    // Host frame sequencer, Gray along the usual path except gap back to idle, which flips all three bits
    typedef enum logic [2:0] {
        SFP_H_IDLE = 3'h0,      // Frame select high, clock idle high
        SFP_H_LEAD = 3'h1,      // Frame select low, before first edge
        SFP_H_LOW  = 3'h3,      // Serial clock low half
        SFP_H_HIGH = 3'h2,      // Serial clock high half
        SFP_H_TAIL = 3'h6,      // Hold after the last edge
        SFP_H_GAP  = 3'h7       // Frame select high time
    } sfp_host_state_e;

    typedef logic [15:0] sfp_word_t;

endpackage

/* verilog/sfp_regs.svh */
// Constants for the serial frame port and its multi-function pins
//
// Behaviour
// - Sample data in on falling serial clock edges
// - Host may clock write-only frames at 50 MHz
// - Host keeps conversion or readback frames at 20 MHz
// - Reset low asynchronously restores default pin configuration
// - Reset stays high except to force a reset
// - Frame select low opens exactly sixteen captured edges
// - Each pin independently converter out/in, digital in/out
// - Top pin optionally shows conversion busy
// - Results and readback leave serially on data out
// - Word MSB driven when frame select falls
// - Next bit on first rising edge after falling
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// Frame geometry
`define SFP_FRAME_BITS        16
`define SFP_CNT_W             5
`define SFP_PIN_COUNT         8
`define SFP_TOP_PIN           7

// Reset value of every pin mode: digital input keeps the pins undriven
`define SFP_PIN_MODE_RST      2'h2
`define SFP_BUSY_EN_RST       1'b0

// Serial clock limits in MHz and the system clock rate in MHz
`define SFP_SCLK_WRITE_MAX_MHZ 50
`define SFP_SCLK_READ_MAX_MHZ  20
`define SFP_SYS_CLK_MHZ        10

// Least half period of the serial clock, in system cycles, rounded up
`define SFP_SCLK_HALF_MIN_CYC \
    ((`SFP_SYS_CLK_MHZ + 2 * `SFP_SCLK_READ_MAX_MHZ - 1) / (2 * `SFP_SCLK_READ_MAX_MHZ))

// Host default half period; 4 gives an 800 ns serial clock
`define SFP_SCLK_HALF_DEF     4

`endif
